// File: rtl/tch_defs.vh
// tch_defs.vh: offsets, field positions, codes and timing of the custom command handler
// assumes inclusion by bare name from the handler source
`ifndef TCH_DEFS_VH
`define TCH_DEFS_VH

// ---------------------------------------------------------------
// apb byte offsets
// ---------------------------------------------------------------
`define TCH_OFS_CMD      8'h00
`define TCH_OFS_ARG_LO   8'h04
`define TCH_OFS_ARG_HI   8'h08
`define TCH_OFS_STATUS   8'h0c
`define TCH_OFS_LOGMODE  8'h10
`define TCH_OFS_LIM_LO   8'h14
`define TCH_OFS_MISC     8'h18
`define TCH_OFS_START    8'h1c
`define TCH_OFS_DLYAPP   8'h20

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define TCH_PREFIX       8'he0
`define TCH_CMD_SET_PW   8'ha0
`define TCH_CMD_SET_MODE 8'ha1
`define TCH_CMD_SET_LIM  8'ha2
`define TCH_CMD_GET_SET  8'ha3

// ---------------------------------------------------------------
// error codes
// ---------------------------------------------------------------
`define TCH_ERR_OTHER    8'h00
`define TCH_ERR_OVERRUN  8'h03
`define TCH_ERR_LOCKED   8'h04
`define TCH_ERR_POWER    8'h0b
`define TCH_ERR_PASSWD   8'ha0
`define TCH_ERR_BATT     8'ha2
`define TCH_ERR_ACTIVE   8'ha3
`define TCH_ERR_BUSY     8'ha6

// ---------------------------------------------------------------
// password levels (level bits 1:0)
// ---------------------------------------------------------------
`define TCH_LVL_NONE     2'h0
`define TCH_LVL_SYS      2'h1
`define TCH_LVL_APP      2'h2
`define TCH_LVL_MEAS     2'h3

// ---------------------------------------------------------------
// log mode field positions
// ---------------------------------------------------------------
`define TCH_LM_FORM_HI   23
`define TCH_LM_FORM_LO   21
`define TCH_LM_RULE      20
`define TCH_LM_EXT1      19
`define TCH_LM_EXT2      18
`define TCH_LM_TEMP      17
`define TCH_LM_BATT      16
`define TCH_LM_IVL_HI    15
`define TCH_LM_IVL_LO    1

// ---------------------------------------------------------------
// status register bits
// ---------------------------------------------------------------
`define TCH_ST_BUSY      0
`define TCH_ST_DONE      1
`define TCH_ST_HDR       2

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define TCH_RST_PW       32'h00000000
`define TCH_RST_MODE     24'h000000
`define TCH_RST_LIM      40'h0000000000
`define TCH_T_REPLY_MS   20
`define TCH_CLK_KHZ      200000

`endif

// File: rtl/tch_custom_cmd.v
// tch_custom_cmd.v: custom command interpreter with apb register access
// assumes the air front end writes decoded commands over apb and sends replies
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`include "tch_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tch_custom_cmd #(
  parameter integer   CW        = 22,
  parameter [CW-1:0]  REPLY_CYC = `TCH_T_REPLY_MS * `TCH_CLK_KHZ
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output wire         pready,
  output reg          pslverr,
  input  wire         rtc_active,
  input  wire         passive_mode,
  input  wire         supply_low,
  input  wire         battery_present,
  input  wire         spi_holds_ee,
  input  wire         meas_holds_ee,
  input  wire [2:0]   area_open,
  input  wire [2:0]   pw_lock,
  input  wire [31:0]  start_time,
  input  wire [15:0]  delay_word,
  input  wire [15:0]  app_word,
  output reg          ee_wr_req,
  output reg  [1:0]   ee_wr_sel,
  output reg  [39:0]  ee_wr_data,
  input  wire         ee_wr_ack,
  input  wire         ee_overrun,
  output reg          reply_valid,
  output reg          reply_hdr,
  output reg  [7:0]   reply_err
);

  // ---------------------------------------------------------------
  // state encoding
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_EVAL = 3'b010;
  localparam [2:0] ST_WR   = 3'b100;

  reg  [2:0]    state_reg;
  reg  [7:0]    code_reg;
  reg  [7:0]    level_reg;
  reg  [31:0]   arg_lo_reg;
  reg  [7:0]    arg_hi_reg;
  reg           done_reg;
  reg  [31:0]   pw_sys_reg;
  reg  [31:0]   pw_app_reg;
  reg  [31:0]   pw_meas_reg;
  reg  [23:0]   mode_reg;
  reg  [39:0]   lim_reg;
  reg  [CW-1:0] tmr_reg;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire acc   = psel & penable;
  wire wr    = acc & pwrite;
  wire busy  = ~state_reg[0];
  wire go    = wr & (paddr == `TCH_OFS_CMD) & ~busy;
  wire clr_done = wr & (paddr == `TCH_OFS_STATUS) & pwdata[`TCH_ST_DONE];

  assign pready = 1'b1;

  // ---------------------------------------------------------------
  // protection view of the three areas
  // ---------------------------------------------------------------
  wire [2:0] prot;
  assign prot[0] = |pw_sys_reg;
  assign prot[1] = |pw_app_reg;
  assign prot[2] = |pw_meas_reg;

  wire [1:0] lvl = level_reg[1:0];
  wire       sys_wr = area_open[0] | ~prot[0];
  reg  [2:0] lvl_hot;

  always @* begin
    case (lvl)
      `TCH_LVL_SYS:  lvl_hot = 3'b001;
      `TCH_LVL_APP:  lvl_hot = 3'b010;
      `TCH_LVL_MEAS: lvl_hot = 3'b100;
      default:       lvl_hot = 3'b000;
    endcase
  end

  // area of the password: open if opened or unprotected
  wire own_open = |(lvl_hot & (area_open | ~prot));

  // ---------------------------------------------------------------
  // error selection, most specific cause first
  // ---------------------------------------------------------------
  wire is_pw   = (code_reg == `TCH_CMD_SET_PW);
  wire is_mode = (code_reg == `TCH_CMD_SET_MODE);
  wire is_lim  = (code_reg == `TCH_CMD_SET_LIM);
  wire is_get  = (code_reg == `TCH_CMD_GET_SET);
  wire is_wr   = is_pw | is_mode | is_lim;

  reg       ev_err;
  reg [7:0] ev_code;

  always @* begin
    ev_err  = 1'b1;
    ev_code = `TCH_ERR_OTHER;
    if (!(is_wr | is_get)) begin
      ev_code = `TCH_ERR_OTHER;
    end else if (is_wr & (spi_holds_ee | meas_holds_ee)) begin
      ev_code = `TCH_ERR_BUSY;
    end else if ((is_mode | is_lim) & rtc_active) begin
      ev_code = `TCH_ERR_ACTIVE;
    end else if (is_wr & passive_mode & supply_low) begin
      ev_code = `TCH_ERR_POWER;
    end else if (is_mode & arg_lo_reg[`TCH_LM_BATT] &
                 passive_mode & ~battery_present) begin
      ev_code = `TCH_ERR_BATT;
    end else if (is_pw & (lvl == `TCH_LVL_NONE)) begin
      ev_code = `TCH_ERR_OTHER;
    end else if (is_pw & |(lvl_hot & pw_lock)) begin
      ev_code = `TCH_ERR_LOCKED;
    end else if (is_pw & ~sys_wr & (lvl == `TCH_LVL_SYS)) begin
      ev_code = `TCH_ERR_PASSWD;
    end else if (is_pw & ~sys_wr & ~own_open) begin
      ev_code = `TCH_ERR_PASSWD;
    end else begin
      ev_err  = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  // the eeprom write is done before the stored copy changes, so a
  // failed or late write never disturbs the live settings
  wire expired = (tmr_reg == REPLY_CYC - {{(CW-1){1'b0}}, 1'b1});

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= ST_IDLE;
      code_reg    <= 8'h00;
      level_reg   <= 8'h00;
      arg_lo_reg  <= 32'h00000000;
      arg_hi_reg  <= 8'h00;
      done_reg    <= 1'b0;
      pw_sys_reg  <= `TCH_RST_PW;
      pw_app_reg  <= `TCH_RST_PW;
      pw_meas_reg <= `TCH_RST_PW;
      mode_reg    <= `TCH_RST_MODE;
      lim_reg     <= `TCH_RST_LIM;
      tmr_reg     <= {CW{1'b0}};
      ee_wr_req   <= 1'b0;
      ee_wr_sel   <= 2'h0;
      ee_wr_data  <= 40'h0000000000;
      reply_valid <= 1'b0;
      reply_hdr   <= 1'b0;
      reply_err   <= 8'h00;
    end else begin
      reply_valid <= 1'b0;
      if (wr & ~busy & (paddr == `TCH_OFS_ARG_LO)) begin
        arg_lo_reg <= pwdata;
      end
      if (wr & ~busy & (paddr == `TCH_OFS_ARG_HI)) begin
        arg_hi_reg <= pwdata[7:0];
      end
      if (clr_done) begin
        done_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          tmr_reg <= {CW{1'b0}};
          if (go) begin
            code_reg  <= pwdata[7:0];
            level_reg <= pwdata[15:8];
            state_reg <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (ev_err | is_get) begin
            reply_valid <= 1'b1;
            reply_hdr   <= ev_err;
            reply_err   <= ev_err ? ev_code : 8'h00;
            done_reg    <= 1'b1;
            state_reg   <= ST_IDLE;
          end else begin
            ee_wr_req <= 1'b1;
            ee_wr_sel <= is_pw ? {1'b0, 1'b0} : (is_mode ? 2'h1 : 2'h2);
            if (is_pw) begin
              ee_wr_data <= {6'h00, lvl, arg_lo_reg};
            end else if (is_mode) begin
              ee_wr_data <= {16'h0000, arg_lo_reg[23:1], 1'b0};
            end else begin
              ee_wr_data <= {arg_hi_reg, arg_lo_reg};
            end
            state_reg <= ST_WR;
          end
        end
        ST_WR: begin
          tmr_reg <= tmr_reg + {{(CW-1){1'b0}}, 1'b1};
          if (ee_wr_ack) begin
            ee_wr_req   <= 1'b0;
            reply_valid <= 1'b1;
            done_reg    <= 1'b1;
            state_reg   <= ST_IDLE;
            if (ee_overrun) begin
              reply_hdr <= 1'b1;
              reply_err <= `TCH_ERR_OVERRUN;
            end else begin
              reply_hdr <= 1'b0;
              reply_err <= 8'h00;
              if (is_pw) begin
                case (lvl)
                  `TCH_LVL_SYS:  pw_sys_reg  <= arg_lo_reg;
                  `TCH_LVL_APP:  pw_app_reg  <= arg_lo_reg;
                  `TCH_LVL_MEAS: pw_meas_reg <= arg_lo_reg;
                  default:       pw_sys_reg  <= pw_sys_reg;
                endcase
              end else if (is_mode) begin
                mode_reg <= {arg_lo_reg[23:1], 1'b0};
              end else begin
                lim_reg <= {arg_hi_reg, arg_lo_reg};
              end
            end
          end else if (expired) begin
            // give up so the reader always hears back in time
            ee_wr_req   <= 1'b0;
            reply_valid <= 1'b1;
            reply_hdr   <= 1'b1;
            reply_err   <= `TCH_ERR_OTHER;
            done_reg    <= 1'b1;
            state_reg   <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          ee_wr_req <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read-back words
  // ---------------------------------------------------------------
  // log mode byte: form, rule, ext1, ext2, low bits reserved
  wire [7:0]  mode_byte = {mode_reg[23:21], mode_reg[20], mode_reg[19],
                           mode_reg[18], 2'b00};
  wire [15:0] ivl_word  = {mode_reg[15:1], 1'b0};
  wire [15:0] dly_word  = {delay_word[15:4], 2'b00, delay_word[1:0]};
  wire [15:0] appd_word = {app_word[15:7], 4'h0, app_word[2:0]};

  always @* begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    if (acc & ~pwrite) begin
      case (paddr)
        `TCH_OFS_CMD:     prdata = {16'h0000, level_reg, code_reg};
        `TCH_OFS_ARG_LO:  prdata = arg_lo_reg;
        `TCH_OFS_ARG_HI:  prdata = {24'h000000, arg_hi_reg};
        `TCH_OFS_STATUS:  prdata = {16'h0000, reply_err, 5'h00,
                                    reply_hdr, done_reg, busy};
        `TCH_OFS_LOGMODE: prdata = {8'h00, mode_reg};
        `TCH_OFS_LIM_LO:  prdata = lim_reg[31:0];
        `TCH_OFS_MISC:    prdata = {lim_reg[39:32], mode_byte, ivl_word};
        `TCH_OFS_START:   prdata = start_time;
        `TCH_OFS_DLYAPP:  prdata = {dly_word, appd_word};
        default:          pslverr = 1'b1;
      endcase
    end else if (acc & pwrite) begin
      case (paddr)
        `TCH_OFS_CMD,
        `TCH_OFS_ARG_LO,
        `TCH_OFS_ARG_HI,
        `TCH_OFS_STATUS:  pslverr = 1'b0;
        default:          pslverr = 1'b1;
      endcase
    end
  end

endmodule // tch_custom_cmd

`default_nettype wire

// File: test/tch_ee_model.sv
// tch_ee_model.sv: eeprom side partner of the command handler
// assumes one clock shared with the handler, async low reset
`timescale 1ns/1ps
`default_nettype none
module tch_ee_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ee_wr_req,
  input  wire logic       ovr,
  input  wire logic       mute,
  input  wire logic [3:0] dly,
  output var  logic       ee_wr_ack,
  output wire logic       ee_overrun
);
  logic [3:0] cnt;
  logic       tog;
  // overrun only means something with ack, so it wanders otherwise
  assign ee_overrun = ee_wr_ack ? ovr : tog;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      tog <= 1'b0;
      ee_wr_ack <= 1'b0;
    end else begin
      tog <= ~tog;
      // mute never answers, forcing the handler's own timeout
      ee_wr_ack <= ee_wr_req && !ee_wr_ack && cnt == dly && !mute;
      cnt <= (ee_wr_req && !ee_wr_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // tch_ee_model
`default_nettype wire

// File: test/tch_custom_cmd_asserts.sv
// tch_custom_cmd_asserts.sv: port checker for the command handler
// assumes the bind below; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module tch_chk #(
  parameter int REPLY_CYC = 20
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ee_wr_req,
  input wire logic [39:0] ee_wr_data,
  input wire logic        ee_wr_ack,
  input wire logic        ee_overrun,
  input wire logic        reply_valid,
  input wire logic        reply_hdr,
  input wire logic [7:0]  reply_err
);
  // ---------------------------------------------------------------
  // reply properties
  // ---------------------------------------------------------------
  localparam int T_LIM = REPLY_CYC + 1;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_err_hdr: assert property (
    reply_valid && reply_err != 8'h00 |-> reply_hdr) else $error("code without header");
  a_ok_code: assert property (
    reply_valid && !reply_hdr |-> reply_err == 8'h00) else $error("success with code");
  a_one_reply: assert property (
    reply_valid |=> !reply_valid) else $error("reply longer than one cycle");
  a_ack_reply: assert property (
    ee_wr_req && ee_wr_ack |=> reply_valid) else $error("no reply after ack");
  a_overrun_code: assert property (
    ee_wr_req && ee_wr_ack && ee_overrun |=> reply_hdr && reply_err == 8'h03)
    else $error("overrun not reported");
  a_write_bound: assert property (
    $rose(ee_wr_req) |-> ##[1:T_LIM] reply_valid) else $error("write reply late");
  a_req_ends: assert property (
    reply_valid |-> !ee_wr_req) else $error("write still requested");
  a_data_hold: assert property (
    ee_wr_req && !ee_wr_ack |=> !ee_wr_req || $stable(ee_wr_data)) else $error("data moved");
  c_err: cover property (reply_valid && reply_hdr);
  c_ok: cover property (reply_valid && !reply_hdr);
  c_ovr: cover property (ee_wr_ack && ee_overrun);
endmodule // tch_chk
bind tch_custom_cmd tch_chk #(.REPLY_CYC(REPLY_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .ee_wr_req(ee_wr_req), .ee_wr_data(ee_wr_data),
  .ee_wr_ack(ee_wr_ack), .ee_overrun(ee_overrun), .reply_valid(reply_valid),
  .reply_hdr(reply_hdr), .reply_err(reply_err));
`default_nettype wire

// File: test/test_tag_custom_cmd_handler.sv
// test_tag_custom_cmd_handler.sv: random command bench with a reference model
// assumes tch_custom_cmd, tch_ee_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, (e), (s)); end end
module test_tag_custom_cmd_handler;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, reply_err;
  logic [31:0] pwdata = 0, prdata, start_time = 0, rd_q, sd = 32'h0e45;
  logic [15:0] delay_word = 0, app_word = 0;
  logic        rtc_active = 0, passive_mode = 0, supply_low = 0, battery_present = 0;
  logic        spi_holds_ee = 0, meas_holds_ee = 0, ovr = 0, mute = 0;
  logic [2:0]  area_open = 0, pw_lock = 0;
  logic [3:0]  dly = 0;
  logic        pready, pslverr, ee_wr_req, ee_wr_ack, ee_overrun, reply_valid, reply_hdr;
  int          wr_cnt = 0;
  logic [1:0]  sel_q = 0;
  logic [39:0] dat_q = 0;
  logic [1:0]  ee_wr_sel;
  logic [39:0] ee_wr_data, li = 0;
  logic [23:0] md = 0;
  logic [31:0] pw [4] = '{0, 0, 0, 0};
  logic [7:0]  codes [8] = '{8'ha0, 8'ha0, 8'ha1, 8'ha1, 8'ha2, 8'ha2, 8'ha3, 8'h5a};
  int          fails = 0, n_tests = 0, cyc = 0;
  tch_custom_cmd #(.REPLY_CYC(22'd20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rtc_active(rtc_active), .passive_mode(passive_mode),
    .supply_low(supply_low), .battery_present(battery_present), .spi_holds_ee(spi_holds_ee),
    .meas_holds_ee(meas_holds_ee), .area_open(area_open), .pw_lock(pw_lock),
    .start_time(start_time), .delay_word(delay_word), .app_word(app_word),
    .ee_wr_req(ee_wr_req), .ee_wr_sel(ee_wr_sel), .ee_wr_data(ee_wr_data),
    .ee_wr_ack(ee_wr_ack), .ee_overrun(ee_overrun), .reply_valid(reply_valid),
    .reply_hdr(reply_hdr), .reply_err(reply_err));
  tch_ee_model u_ee (.pclk(pclk), .presetn(presetn), .ee_wr_req(ee_wr_req), .ovr(ovr),
    .mute(mute), .dly(dly), .ee_wr_ack(ee_wr_ack), .ee_overrun(ee_overrun));
  always #2.5 pclk = ~pclk;
  // eeprom writes that the model acknowledged, with what they carried
  always @(posedge pclk) begin
    if (ee_wr_req && ee_wr_ack) begin
      wr_cnt <= wr_cnt + 1;
      sel_q <= ee_wr_sel;
      dat_q <= ee_wr_data;
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // tasks and reference model
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    repeat (32) sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
    return sd;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [8:0] exp_reply(logic [7:0] c, logic [1:0] l, logic b16);
    logic wr;
    logic sw;
    wr = c inside {8'ha0, 8'ha1, 8'ha2};
    sw = area_open[0] || pw[1] == 0;
    if (!wr && c != 8'ha3) return 9'h100;
    if (wr && (spi_holds_ee || meas_holds_ee)) return 9'h1a6;
    if (wr && rtc_active && c != 8'ha0) return 9'h1a3;
    if (wr && passive_mode && supply_low) return 9'h10b;
    if (c == 8'ha1 && b16 && passive_mode && !battery_present) return 9'h1a2;
    if (c == 8'ha0) begin
      if (l == 2'h0) return 9'h100;
      if (pw_lock[l-1]) return 9'h104;
      if (!sw && (l == 2'h1 || (pw[l] != 0 && !area_open[l-1]))) return 9'h1a0;
    end
    if (wr && mute) return 9'h100;
    if (wr && ovr) return 9'h103;
    return 9'h000;
  endfunction
  task automatic run_cmd();
    logic [31:0] r, q;
    logic [39:0] ar, ed;
    logic [8:0]  ex;
    logic [1:0]  es;
    int          n0;
    logic [7:0]  cd, lv;
    logic        e;
    r = rnd();
    ar = {r[7:0], rnd()};
    cd = codes[r[10:8]];
    lv = r[23:16];
    r = rnd();
    rtc_active <= r[2:0] == 0;
    passive_mode <= r[4:3] == 0;
    supply_low <= r[6:5] == 0;
    battery_present <= r[7];
    spi_holds_ee <= r[10:8] == 0;
    meas_holds_ee <= r[13:11] == 0;
    area_open <= r[16:14];
    pw_lock <= r[19:17] & r[22:20] & r[25:23];
    ovr <= r[28:26] == 0;
    mute <= r[31:29] == 0;
    r = rnd();
    dly <= {1'b0, r[2:0]};
    start_time <= rnd();
    delay_word <= r[31:16];
    app_word <= r[15:0];
    apb(1'b1, 8'h04, ar[31:0], q, e);
    apb(1'b1, 8'h08, {24'h0, ar[39:32]}, q, e);
    n0 = wr_cnt;
    apb(1'b1, 8'h00, {16'h0, lv, cd}, q, e);
    ex = exp_reply(cd, lv[1:0], ar[16]);
    for (int k = 0; k < 60 && reply_valid !== 1'b1; k++) @(negedge pclk);
    `CHK("reply", 1'b1, reply_valid)
    `CHK("header", ex[8], reply_hdr)
    `CHK("code", ex[7:0], reply_err)
    if (!ex[8] && cd == 8'ha0) pw[lv[1:0]] = ar[31:0];
    if (!ex[8] && cd == 8'ha1) md = ar[23:0];
    if (!ex[8] && cd == 8'ha2) li = ar;
    @(posedge pclk);
    if (cd != 8'ha3 && (!ex[8] || ex == 9'h103)) begin
      es = (cd == 8'ha0) ? 2'h0 : ((cd == 8'ha1) ? 2'h1 : 2'h2);
      if (cd == 8'ha0) ed = {6'h0, lv[1:0], ar[31:0]};
      else if (cd == 8'ha1) ed = {16'h0, ar[23:1], 1'b0};
      else ed = ar;
      `CHK("wr_count", n0 + 1, wr_cnt)
      `CHK("wr_sel", es, sel_q)
      `CHK("wr_data", ed, dat_q)
    end else begin
      `CHK("no_write", n0, wr_cnt)
    end
    apb(1'b0, 8'h0c, 32'h0, q, e);
    `CHK("status", {16'h0, ex[7:0], 5'h0, ex[8], 2'b10}, q)
    apb(1'b1, 8'h0c, 32'h2, q, e);
    apb(1'b0, 8'h0c, 32'h0, q, e);
    `CHK("status_clr", {16'h0, ex[7:0], 5'h0, ex[8], 2'b00}, q)
  endtask
  task automatic read_back();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 8'h10, 32'h0, q, e);
    `CHK("logmode", {8'h0, md[23:1], 1'b0}, q)
    apb(1'b0, 8'h14, 32'h0, q, e);
    `CHK("lim_lo", li[31:0], q)
    apb(1'b0, 8'h18, 32'h0, q, e);
    `CHK("misc", {li[39:32], md[23:18], 2'b00, md[15:1], 1'b0}, q)
    apb(1'b0, 8'h1c, 32'h0, q, e);
    `CHK("start", start_time, q)
    apb(1'b0, 8'h20, 32'h0, q, e);
    `CHK("dlyapp", {delay_word[15:4], 2'b00, delay_word[1:0], app_word[15:7], 4'h0,
      app_word[2:0]}, q)
    apb(1'b0, 8'h24, 32'h0, q, e);
    `CHK("unmapped", 1'b1, e)
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_back();
    for (int i = 0; i < 300; i++) begin
      run_cmd();
      if (i % 4 == 3) read_back();
    end
    close_out();
  end
endmodule // test_tag_custom_cmd_handler
`default_nettype wire
